// *** rtl/espl_regs.vh ***
/*
 * Constants for the engine start permission logic: register offsets,
 * field positions, reset values, power mode codes and timing counts.
 * Assumes a 20 MHz clock and AXI4-Lite byte addressing.
 */
`ifndef ESPL_REGS_VH
`define ESPL_REGS_VH

// Register byte offsets
`define ESPL_CTRL_OFS 8'h00
`define ESPL_STAT_OFS 8'h04
`define ESPL_MSG_OFS 8'h08
`define ESPL_GRACE_OFS 8'h0c

// Control register fields
`define ESPL_CTRL_CLUTCH_REQ 0
`define ESPL_CTRL_GEAR_SW 1
`define ESPL_CTRL_AUTO_TRANS 2
`define ESPL_CTRL_REMOTE_FIT 3
`define ESPL_CTRL_PUSH_FIT 4
`define ESPL_CTRL_RESET 32'h0000_0000

// Status register fields
`define ESPL_STAT_CRANK 0
`define ESPL_STAT_QUAL 1
`define ESPL_STAT_DISCRETE 2
`define ESPL_STAT_GRACE 3
`define ESPL_STAT_FUEL_OFF 4
`define ESPL_STAT_SHORT 5
`define ESPL_STAT_WAKE 6

// Power mode codes
`define ESPL_PM_OFF 2'h0
`define ESPL_PM_ACC 2'h1
`define ESPL_PM_RUN 2'h2
`define ESPL_PM_CRANK 2'h3

// Serial message identifiers
`define ESPL_ID_PM_PRI 8'hfe
`define ESPL_ID_PM_SEC 8'h06
`define ESPL_ID_ABORT_PRI 8'h86
`define ESPL_ID_ABORT_SEC 8'h15

// Timing: one second after engine start, in ms, and the clock rate
`define ESPL_START_WIN_MS 1000
`define ESPL_CLK_HZ 20000000
`define ESPL_START_WIN_CYC ((`ESPL_START_WIN_MS * (`ESPL_CLK_HZ / 1000)))
`define ESPL_GRACE_RESET 32'h0100_0000

`endif

// *** rtl/espl_sync.v ***
/*
 * Three-stage synchroniser with agreement filter for one pin input.
 * Assumes the pin is asynchronous to aclk.
 */
`timescale 1ns/10ps
module espl_sync (
  input wire aclk,
  input wire aresetn,
  input wire pin,
  output reg level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // Three flops; level changes once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule // espl_sync

// *** rtl/espl_timer.v ***
/*
 * Down counter that runs while armed and drops its busy flag when it reaches zero.
 * Assumes load and run come from logic on the same clock.
 */
`timescale 1ns/10ps
module espl_timer #(
  parameter WIDTH = 32
) (
  input wire aclk,
  input wire aresetn,
  input wire load,
  input wire [WIDTH-1:0] load_val,
  input wire run,
  output reg busy_q
);
  reg [WIDTH-1:0] cnt_q;

  // Load wins; otherwise count down while run holds
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= {WIDTH{1'b0}};
      busy_q <= 1'b0;
    end else if (load) begin
      cnt_q <= load_val;
      busy_q <= (load_val != {WIDTH{1'b0}});
    end else if (!run) begin
      cnt_q <= {WIDTH{1'b0}};
      busy_q <= 1'b0;
    end else if (cnt_q != {WIDTH{1'b0}}) begin
      cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
      busy_q <= (cnt_q != {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
endmodule // espl_timer

// *** rtl/espl_core.v ***
/*
 * Engine start permission logic: crank permission, restart grace mode,
 * neutral source selection, starter low-side drive, starter short test
 * and fuel inhibit, with an AXI4-Lite register slave.
 * Assumes decoded serial power mode words arrive on aclk with a strobe,
 * and discrete switch pins are asynchronous.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "espl_regs.vh"

// Summary of operation
// - Crank only in power mode CRANK after park/neutral or clutch qualification.
// - Clutch counts toward qualification only when clutch start is configured.
// - With both masters lost, power mode comes from discrete inputs.
// - Discrete-derived power mode never starts cranking by itself.
// - Discrete cranking is allowed only during restart grace mode.
// - Grace mode needs theft pass, engine stopped and serial mode lost.
// - Stop cranking on discrete request or power mode other than CRANK.
// - Accessory and run/crank inputs drive starter control and wake-up.
// - Use internal gear switches when fitted, else external neutral switch.
// - Starter output is a low-side driver, low to engage the relay.
// - With internal gear switches, test the starter line for shorts to ground.
// - Disable fuel on short, in gear, and engine stopped or under one second.
// - Send crank-aborted message 86/15 when remote or push start fitted.
// - Receive power mode message FE/06 as the crank request source.
// - Accept remote crank requests only on automatic transmission vehicles.
// - Grace mode lasts a bounded time; then only serial mode may start.
module espl_core #(
  parameter START_WIN_CYC = `ESPL_START_WIN_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire msg_valid,
  input wire [7:0] msg_pri_id,
  input wire [7:0] msg_sec_id,
  input wire [1:0] msg_pm,
  input wire pm_master_lost,
  input wire pm_backup_lost,
  input wire remote_crank_req,
  input wire theft_deterrent_pass,
  input wire engine_rotating,
  input wire engine_running,
  input wire in_gear,
  input wire internal_gear_switches_pn,
  input wire acc_pin,
  input wire run_crank_pin,
  input wire neutral_pin,
  input wire clutch_pin,
  input wire starter_sense_pin,
  output reg starter_drive_n_q,
  output reg fuel_disable_q,
  output reg wake_q,
  output reg abort_valid_q,
  output reg [7:0] abort_pri_q,
  output reg [7:0] abort_sec_q
);
  wire acc_s;
  wire run_s;
  wire neutral_s;
  wire clutch_s;
  wire sense_s;
  wire grace_busy;
  wire start_busy;
  reg [31:0] ctrl_q;
  reg [31:0] grace_len_q;
  reg [1:0] pm_q;
  reg pm_fresh_q;
  reg qual_q;
  reg crank_q;
  reg grace_q;
  reg grace_load_q;
  reg rot_q;
  reg run_q;
  reg short_q;
  reg [4:0] rel_q;
  reg fuel_off_latch_q;
  reg [7:0] aborts_q;
  reg aw_q;
  reg w_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rdata_d;
  reg pn_d;
  reg qual_now_d;
  reg discrete_d;
  reg [1:0] pm_eff_d;
  reg crank_d;
  reg serial_lost_d;
  integer i;

  // Pin synchronisers for the discrete switch inputs and the starter sense line
  genvar g;
  wire [4:0] pins = {starter_sense_pin, clutch_pin, neutral_pin, run_crank_pin, acc_pin};
  wire [4:0] pins_s;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sync
      espl_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(pins[g]),
        .level_q(pins_s[g])
      );
    end
  endgenerate
  assign acc_s = pins_s[0];
  assign run_s = pins_s[1];
  assign neutral_s = pins_s[2];
  assign clutch_s = pins_s[3];
  assign sense_s = pins_s[4];

  // Restart grace window, started when the engine stops rotating
  espl_timer #(.WIDTH(32)) u_grace (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(grace_load_q),
    .load_val(grace_len_q),
    .run(theft_deterrent_pass),
    .busy_q(grace_busy)
  );

  // One second window after engine start
  espl_timer #(.WIDTH(32)) u_start (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(engine_running & ~run_q),
    .load_val(START_WIN_CYC[31:0]),
    .run(engine_running),
    .busy_q(start_busy)
  );

  // Permission decision
  always @* begin
    serial_lost_d = pm_master_lost & pm_backup_lost;
    discrete_d = serial_lost_d;
    if (run_s) begin
      pm_eff_d = `ESPL_PM_RUN;
    end else if (acc_s) begin
      pm_eff_d = `ESPL_PM_ACC;
    end else begin
      pm_eff_d = `ESPL_PM_OFF;
    end
    if (ctrl_q[`ESPL_CTRL_GEAR_SW]) begin
      pn_d = internal_gear_switches_pn;
    end else begin
      pn_d = neutral_s;
    end
    qual_now_d = pn_d | (ctrl_q[`ESPL_CTRL_CLUTCH_REQ] & clutch_s);
    if (discrete_d) begin
      // Only grace mode lets the run/crank input start the engine
      crank_d = grace_q & run_s & (qual_q | qual_now_d);
    end else begin
      crank_d = (pm_q == `ESPL_PM_CRANK) & qual_q;
    end
    // A remote crank request is refused unless the vehicle is set up as
    // an automatic; refusing it also holds the starter off
    if (remote_crank_req & ~ctrl_q[`ESPL_CTRL_AUTO_TRANS]) begin
      crank_d = 1'b0;
    end
    // Serial mode: both discrete inputs low ends cranking
    if (!discrete_d & ~run_s & ~acc_s) begin
      crank_d = 1'b0;
    end
  end

  // Power mode reception, qualification, grace mode and starter drive
  always @(posedge aclk) begin
    if (!aresetn) begin
      pm_q <= `ESPL_PM_OFF;
      pm_fresh_q <= 1'b0;
      qual_q <= 1'b0;
      crank_q <= 1'b0;
      grace_q <= 1'b0;
      grace_load_q <= 1'b0;
      rot_q <= 1'b0;
      run_q <= 1'b0;
      starter_drive_n_q <= 1'b1;
      wake_q <= 1'b0;
      abort_valid_q <= 1'b0;
      abort_pri_q <= 8'h00;
      abort_sec_q <= 8'h00;
      aborts_q <= 8'h00;
    end else begin
      rot_q <= engine_rotating;
      run_q <= engine_running;
      pm_fresh_q <= 1'b0;
      if (msg_valid && msg_pri_id == `ESPL_ID_PM_PRI && msg_sec_id == `ESPL_ID_PM_SEC) begin
        pm_q <= msg_pm;
        pm_fresh_q <= 1'b1;
      end else if (discrete_d) begin
        pm_q <= pm_eff_d;
      end
      // Qualification tracks the live inputs outside CRANK in serial mode, latches in CRANK or discrete mode
      if (pm_q != `ESPL_PM_CRANK && !discrete_d) begin
        qual_q <= qual_now_d;
      end else if (qual_now_d) begin
        qual_q <= 1'b1;
      end
      // Grace mode: theft pass, engine stopped, serial mode lost
      grace_load_q <= rot_q & ~engine_rotating & theft_deterrent_pass;
      grace_q <= theft_deterrent_pass & ~engine_rotating & serial_lost_d &
        (grace_busy | grace_load_q);
      // Starter output registered; released whenever the decision drops
      crank_q <= crank_d;
      starter_drive_n_q <= ~crank_d;
      wake_q <= acc_s | run_s;
      abort_valid_q <= 1'b0;
      // Report an aborted crank once, as the decision drops before the engine turns
      if (crank_q & ~crank_d & ~engine_rotating &
          (ctrl_q[`ESPL_CTRL_REMOTE_FIT] | ctrl_q[`ESPL_CTRL_PUSH_FIT])) begin
        abort_valid_q <= 1'b1;
        abort_pri_q <= `ESPL_ID_ABORT_PRI;
        abort_sec_q <= `ESPL_ID_ABORT_SEC;
        aborts_q <= aborts_q + 8'h01;
      end
    end
  end

  // Short test: line reads low while the driver is released.
  // The sense pin needs about four edges through its synchroniser, so
  // the test waits until the driver has been released for five edges;
  // otherwise every end of cranking would look like a short.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rel_q <= 5'h00;
      short_q <= 1'b0;
      fuel_off_latch_q <= 1'b0;
      fuel_disable_q <= 1'b0;
    end else begin
      rel_q <= {rel_q[3:0], starter_drive_n_q};
      short_q <= ctrl_q[`ESPL_CTRL_GEAR_SW] & starter_drive_n_q & (&rel_q) &
        ~sense_s;
      // The start window loads on the first running edge, so that edge counts too
      fuel_off_latch_q <= short_q & in_gear & (~engine_running | ~run_q | start_busy);
      fuel_disable_q <= short_q & in_gear & (~engine_running | ~run_q | start_busy);
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_q <= `ESPL_CTRL_RESET;
      grace_len_q <= `ESPL_GRACE_RESET;
    end else begin
      s_axi_awready <= ~aw_q & ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid;
      s_axi_wready <= ~w_q & ~s_axi_wready & ~s_axi_bvalid & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_q & w_q & ~s_axi_bvalid) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        for (i = 0; i < 4; i = i + 1) begin
          if (wstrb_q[i] && awaddr_q == `ESPL_CTRL_OFS) begin
            ctrl_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
          end
          if (wstrb_q[i] && awaddr_q == `ESPL_GRACE_OFS) begin
            grace_len_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
          end
        end
        if (awaddr_q != `ESPL_CTRL_OFS && awaddr_q != `ESPL_GRACE_OFS) begin
          s_axi_bresp <= 2'b10; // Unmapped or read-only
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data mux
  always @* begin
    case (s_axi_araddr[7:0])
      `ESPL_CTRL_OFS: rdata_d = ctrl_q;
      `ESPL_STAT_OFS: rdata_d = {25'h0, wake_q, short_q, fuel_disable_q, grace_q,
        discrete_d, qual_q, crank_q};
      `ESPL_MSG_OFS: rdata_d = {14'h0, pm_fresh_q, fuel_off_latch_q, aborts_q, 6'h0, pm_q};
      `ESPL_GRACE_OFS: rdata_d = grace_len_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // AXI4-Lite read path, one cycle to accept and one to answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        case (s_axi_araddr[7:0])
          `ESPL_CTRL_OFS, `ESPL_STAT_OFS, `ESPL_MSG_OFS, `ESPL_GRACE_OFS: begin
            s_axi_rresp <= 2'b00;
          end
          default: begin
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // espl_core

// *** tb/espl_chk.sv ***
/* Assertion checker for espl_core ports.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/10ps
module espl_chk (
  input wire aclk,
  input wire aresetn,
  input wire msg_valid,
  input wire [7:0] msg_pri_id,
  input wire [7:0] msg_sec_id,
  input wire [1:0] msg_pm,
  input wire pm_master_lost,
  input wire pm_backup_lost,
  input wire theft_deterrent_pass,
  input wire in_gear,
  input wire acc_pin,
  input wire run_crank_pin,
  input wire starter_drive_n_q,
  input wire fuel_disable_q,
  input wire wake_q,
  input wire abort_valid_q,
  input wire [7:0] abort_pri_q,
  input wire [7:0] abort_sec_q
);
  reg [1:0] pm_q;
  wire lost = pm_master_lost & pm_backup_lost;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Last mode carried by a power mode message
  always @(posedge aclk) begin
    if (!aresetn)
      pm_q <= 2'h0;
    else if (msg_valid && msg_pri_id == 8'hfe && msg_sec_id == 8'h06)
      pm_q <= msg_pm;
  end
  a_crank_needs_pm: assert property (
    $fell(starter_drive_n_q) && !$past(lost) |-> $past(pm_q) == 2'h3)
    else $error("crank began outside crank mode");
  a_leave_crank_stop: assert property (
    (pm_q != 2'h3 && !lost) [*3] |-> starter_drive_n_q)
    else $error("starter held outside crank mode");
  a_reset_idle: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> starter_drive_n_q && !fuel_disable_q)
    else $error("outputs active after reset");
  a_abort_ids: assert property (
    abort_valid_q |-> abort_pri_q == 8'h86 && abort_sec_q == 8'h15)
    else $error("abort identifiers wrong");
  a_abort_pulse: assert property (abort_valid_q |=> !abort_valid_q)
    else $error("abort pulse too long");
  a_fuel_in_gear: assert property ($rose(fuel_disable_q) |-> $past(in_gear))
    else $error("fuel cut while not in gear");
  a_wake_idle: assert property ((!acc_pin && !run_crank_pin) [*8] |-> !wake_q)
    else $error("wake with both pins low");
  a_discrete_block: assert property (
    (lost && !theft_deterrent_pass) [*4] |-> starter_drive_n_q)
    else $error("discrete crank without grace");
endmodule // espl_chk

bind espl_core espl_chk chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .msg_valid(msg_valid),
  .msg_pri_id(msg_pri_id),
  .msg_sec_id(msg_sec_id),
  .msg_pm(msg_pm),
  .pm_master_lost(pm_master_lost),
  .pm_backup_lost(pm_backup_lost),
  .theft_deterrent_pass(theft_deterrent_pass),
  .in_gear(in_gear),
  .acc_pin(acc_pin),
  .run_crank_pin(run_crank_pin),
  .starter_drive_n_q(starter_drive_n_q),
  .fuel_disable_q(fuel_disable_q),
  .wake_q(wake_q),
  .abort_valid_q(abort_valid_q),
  .abort_pri_q(abort_pri_q),
  .abort_sec_q(abort_sec_q)
);

// *** tb/espl_far.sv ***
/* Power mode master and switch model facing espl_core.
   Assumes the bench sets key, link loss and switch states. */
`timescale 1ns/10ps
module espl_far (
  input wire aclk,
  input wire aresetn,
  input wire [1:0] key,
  input wire silent,
  input wire park,
  input wire pedal_deep,
  input wire short_gnd,
  input wire starter_drive_n_q,
  output reg msg_valid = 1'b0,
  output reg [7:0] msg_pri_id = 8'h00,
  output reg [7:0] msg_sec_id = 8'h00,
  output reg [1:0] msg_pm = 2'h0,
  output reg pm_master_lost = 1'b0,
  output reg pm_backup_lost = 1'b0,
  output wire acc_pin,
  output wire run_crank_pin,
  output wire neutral_pin,
  output wire clutch_pin,
  output wire starter_sense_pin
);
  // Mode broadcast mirrors the key, so crank is sent only in crank
  always @(posedge aclk) begin
    msg_valid <= aresetn && !silent;
    msg_pri_id <= 8'hfe;
    msg_sec_id <= 8'h06;
    msg_pm <= key;
    pm_master_lost <= silent;
    pm_backup_lost <= silent;
  end
  // Switches close to run/crank level
  assign run_crank_pin = key[1];
  assign acc_pin = key == 2'h1 || key == 2'h2;
  assign neutral_pin = park;
  assign clutch_pin = pedal_deep;
  // Line reads high through the relay coil while the driver is released, unless shorted
  assign starter_sense_pin = starter_drive_n_q & ~short_gnd;
endmodule // espl_far

// *** tb/tb.sv ***
/* Self-checking bench for espl_core.
   Assumes espl_far and espl_chk are compiled first. */
`timescale 1ns/10ps
`define C(n, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb;
  logic aclk, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_arvalid = 0, s_axi_rready = 0, remote_crank_req = 0;
  logic theft_deterrent_pass = 0, engine_rotating = 0, engine_running = 0;
  logic in_gear = 0, internal_gear_switches_pn = 0, silent = 0, park = 0;
  logic pedal_deep = 0, short_gnd = 0;
  logic [1:0] key = 0, r;
  logic [31:0] d;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, msg_pm;
  wire [31:0] s_axi_rdata;
  wire msg_valid, pm_master_lost, pm_backup_lost, acc_pin, run_crank_pin;
  wire neutral_pin, clutch_pin, starter_sense_pin, starter_drive_n_q;
  wire fuel_disable_q, wake_q, abort_valid_q;
  wire [7:0] msg_pri_id, msg_sec_id, abort_pri_q, abort_sec_q;
  int fails = 0, n_checks = 0, aborts = 0;
  typedef struct {logic [4:0] c; logic [1:0] k; logic p, cl, g, rm, e;} espl_row_t;
  espl_row_t rows [8] = '{
    '{5'h00, 2'h3, 1, 0, 0, 0, 0},
    '{5'h00, 2'h3, 0, 1, 0, 0, 1},
    '{5'h01, 2'h3, 0, 1, 0, 0, 0},
    '{5'h00, 2'h2, 1, 0, 0, 0, 1},
    '{5'h02, 2'h3, 0, 0, 1, 0, 0},
    '{5'h02, 2'h3, 1, 0, 0, 0, 1},
    '{5'h00, 2'h3, 1, 0, 0, 1, 1},
    '{5'h04, 2'h3, 1, 0, 0, 1, 0}};
  espl_core #(.START_WIN_CYC(50)) uut (.*);
  espl_far far (.*);
  // Clock and abort pulse count
  initial begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) if (abort_valid_q === 1'b1) aborts <= aborts + 1;
  task w(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task axw(input [7:0] a, input [31:0] v, output [1:0] rs);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task axr(input [7:0] a, output [31:0] v, output [1:0] rs);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
  // Main sequence
  initial begin
    w(3);
    aresetn <= 1;
    @(posedge aclk);
    `C("starter", 1'b1, starter_drive_n_q)
    axr(8'h0c, d, r);
    `C("grace", 32'h0100_0000, d)
    axr(8'h10, d, r);
    `C("rresp", 2'b10, r)
    `C("rdata", 32'h0, d)
    axw(8'h04, 32'h1, r);
    `C("bresp", 2'b10, r)
    foreach (rows[i]) begin
      key <= 0;
      park <= 0;
      pedal_deep <= 0;
      w(12);
      axw(8'h00, {27'h0, rows[i].c}, r);
      park <= rows[i].p;
      pedal_deep <= rows[i].cl;
      internal_gear_switches_pn <= rows[i].g;
      remote_crank_req <= rows[i].rm;
      w(10);
      key <= rows[i].k;
      w(20);
      `C("starter", rows[i].e, starter_drive_n_q)
      `C("wake", 1'b1, wake_q)
    end
    // Latched qualification and abort report
    remote_crank_req <= 0;
    internal_gear_switches_pn <= 0;
    key <= 0;
    axw(8'h00, 32'h08, r);
    w(10);
    key <= 3;
    w(20);
    park <= 0;
    w(10);
    `C("latched", 1'b0, starter_drive_n_q)
    key <= 2;
    w(20);
    `C("aborts", 1, aborts)
    key <= 3;
    w(20);
    `C("requalify", 1'b1, starter_drive_n_q)
    // Serial loss, then restart grace
    key <= 0;
    axw(8'h00, 32'h0, r);
    axw(8'h0c, 32'd40, r);
    silent <= 1;
    park <= 1;
    key <= 3;
    w(20);
    `C("discrete", 1'b1, starter_drive_n_q)
    axr(8'h04, d, r);
    `C("mode", 1'b1, d[2])
    theft_deterrent_pass <= 1;
    engine_rotating <= 1;
    w(5);
    engine_rotating <= 0;
    w(12);
    `C("grace crank", 1'b0, starter_drive_n_q)
    w(60);
    `C("grace over", 1'b1, starter_drive_n_q)
    // Shorted starter line in gear
    silent <= 0;
    key <= 0;
    short_gnd <= 1;
    in_gear <= 1;
    w(12);
    `C("no test", 1'b0, fuel_disable_q)
    axw(8'h00, 32'h02, r);
    w(12);
    `C("fuel", 1'b1, fuel_disable_q)
    engine_running <= 1;
    w(30);
    `C("window", 1'b1, fuel_disable_q)
    w(40);
    `C("late", 1'b0, fuel_disable_q)
    // Stall in gear with the short still there, then a reset in mid-run
    engine_running <= 0;
    w(12);
    `C("stalled", 1'b1, fuel_disable_q)
    aresetn <= 0;
    w(3);
    aresetn <= 1;
    @(posedge aclk);
    `C("reset fuel", 1'b0, fuel_disable_q)
    `C("reset starter", 1'b1, starter_drive_n_q)
    axr(8'h0c, d, r);
    `C("grace reset", 32'h0100_0000, d)
    w(12);
    `C("test off", 1'b0, fuel_disable_q)
    give_verdict;
  end
endmodule // tb
